// ### core/iwd_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none

module iwd_tick_gen
  import iwd_pkg::*;
#(
  parameter int TICK_CYCLES = IWD_TICK_CYCLES  // Clock cycles per one second tick
) (
  input  wire logic i_clock,    // System clock
  input  wire logic i_resetn,   // Asynchronous reset, active low
  input  wire logic i_restart,  // Restart the second from zero
  input  wire logic i_enable,   // Count only while the watchdog runs
  output var  logic o_tick      // One-cycle pulse per elapsed second
);

  localparam int CNT_W = $clog2(TICK_CYCLES + 1);                 // Counter width
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TICK_CYCLES - 1); // Last count

  logic [CNT_W-1:0] cnt_r;    // Cycles into the current second
  logic [CNT_W-1:0] cnt_nxt;  // Next count
  logic             tick_r;   // Registered tick
  logic             tick_nxt; // Next tick

  //----------------------------------------------------------------------
  // Prescaler next state
  //----------------------------------------------------------------------
  // Restart clears the partial second so a refresh gives whole seconds
  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (i_restart || !i_enable) begin
      cnt_nxt = '0;
    end else if (cnt_r == CNT_LAST) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
  end

  // Register the prescaler
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign o_tick = tick_r;

endmodule : iwd_tick_gen

`default_nettype wire

// ### core/iwd_top.sv
`timescale 1ns/1ps
`default_nettype none

module iwd_top
  import iwd_pkg::*;
#(
  parameter int       TICK_CYCLES  = IWD_TICK_CYCLES,  // Cycles per second, shorten in sim
  parameter int       PULSE_CYCLES = IWD_PULSE_CYCLES, // Expiry pulse length
  parameter bit       EXPIRE_IRQ   = 1'b0              // 1: interrupt, 0: processor reset
) (
  input  wire logic                  i_clock,     // System clock, 25 MHz
  input  wire logic                  i_resetn,    // Asynchronous reset, active low
  input  wire logic [IWD_ADDR_W-1:0] i_io_addr,   // I/O address pins
  input  wire logic                  i_aen,       // DMA address enable, high blocks decode
  input  wire logic                  i_iow_n,     // I/O write strobe, active low
  input  wire logic                  i_ior_n,     // I/O read strobe, active low
  input  wire logic [IWD_DATA_W-1:0] i_data,      // Data bus in
  output var  logic [IWD_DATA_W-1:0] o_data,      // Data bus out
  output var  logic                  o_data_oe_n, // Data bus drive, low while driving
  output var  logic                  o_cpu_reset, // Processor reset pulse, active high
  output var  logic                  o_irq,       // Interrupt request pulse, active high
  output var  logic                  o_running    // Watchdog armed and counting
);

  //----------------------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------------------
  localparam int SYNC_W = IWD_ADDR_W + IWD_DATA_W + 3;  // All bus pins in one vector
  localparam logic [IWD_PULSE_W-1:0] PULSE_LAST = IWD_PULSE_W'(PULSE_CYCLES - 1);

  logic [SYNC_W-1:0] sync1_r;  // First stage, read only by the second
  logic [SYNC_W-1:0] sync2_r;  // Second stage
  logic [SYNC_W-1:0] sync3_r;  // Third stage

  // Three flops on every pin; the bus is asynchronous to our clock
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_r <= {{(SYNC_W-2){1'b0}}, 2'b11};
      sync2_r <= {{(SYNC_W-2){1'b0}}, 2'b11};
      sync3_r <= {{(SYNC_W-2){1'b0}}, 2'b11};
    end else begin
      sync1_r <= {i_io_addr, i_data, i_aen, i_ior_n, i_iow_n};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  //----------------------------------------------------------------------
  // Strobe filtering and port decode
  //----------------------------------------------------------------------
  logic [IWD_ADDR_W-1:0] addr_s;    // Synchronised address
  logic [IWD_DATA_W-1:0] data_s;    // Synchronised write data
  logic                  aen_s;     // Synchronised address enable
  logic                  ior_agree; // Read strobe stages agree
  logic                  iow_agree; // Write strobe stages agree
  logic                  sel;       // Our port addressed
  logic                  wr_evt;    // Write strobe just asserted on our port
  logic                  rd_evt;    // Read strobe just asserted on our port
  logic                  rd_end;    // Read strobe just released
  logic                  code_ok;   // Written code within 01h..3Fh

  assign addr_s    = sync3_r[SYNC_W-1 -: IWD_ADDR_W];
  assign data_s    = sync3_r[3 +: IWD_DATA_W];
  assign aen_s     = sync3_r[2];
  assign ior_agree = (sync2_r[1] == sync3_r[1]);
  assign iow_agree = (sync2_r[0] == sync3_r[0]);

  logic ior_lvl_r;    // Accepted read strobe level
  logic ior_lvl_nxt;  // Next read strobe level
  logic iow_lvl_r;    // Accepted write strobe level
  logic iow_lvl_nxt;  // Next write strobe level

  // A strobe change counts only once stages two and three agree
  always_comb begin
    ior_lvl_nxt = ior_agree ? sync3_r[1] : ior_lvl_r;
    iow_lvl_nxt = iow_agree ? sync3_r[0] : iow_lvl_r;
    sel         = !aen_s && (addr_s == IWD_PORT_ADDR);
    wr_evt      = iow_lvl_r && !iow_lvl_nxt && sel;
    rd_evt      = ior_lvl_r && !ior_lvl_nxt && sel;
    rd_end      = !ior_lvl_r && ior_lvl_nxt;
    code_ok     = (data_s >= IWD_CODE_MIN) && (data_s <= IWD_CODE_MAX);
  end

  // Register the strobe levels
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ior_lvl_r <= 1'b1;
      iow_lvl_r <= 1'b1;
    end else begin
      ior_lvl_r <= ior_lvl_nxt;
      iow_lvl_r <= iow_lvl_nxt;
    end
  end

  //----------------------------------------------------------------------
  // One second time base
  //----------------------------------------------------------------------
  logic tick;     // One-cycle pulse per elapsed second
  logic restart;  // Accepted write, restarts the second

  assign restart = wr_evt && code_ok;

  iwd_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .i_clock   (i_clock),
    .i_resetn  (i_resetn),
    .i_restart (restart),
    .i_enable  (o_running),
    .o_tick    (tick)
  );

  //----------------------------------------------------------------------
  // Watchdog control
  //----------------------------------------------------------------------
  iwd_state_t            state_r;      // Watchdog state
  iwd_state_t            state_nxt;    // Next state
  logic [5:0]            interval_r;   // Last accepted interval code
  logic [5:0]            interval_nxt; // Next interval code
  logic [5:0]            remain_r;     // Whole seconds still to run
  logic [5:0]            remain_nxt;   // Next remaining seconds
  logic [IWD_PULSE_W-1:0] pulse_r;     // Expiry pulse cycles left
  logic [IWD_PULSE_W-1:0] pulse_nxt;   // Next pulse count
  logic                  reset_nxt;    // Next processor reset output
  logic                  irq_nxt;      // Next interrupt output
  logic                  run_nxt;      // Next running flag
  logic [IWD_DATA_W-1:0] rdata_nxt;    // Next read data
  logic                  oe_n_nxt;     // Next data drive enable

  // Host accesses take priority over the countdown in the same cycle
  always_comb begin
    state_nxt    = state_r;
    interval_nxt = interval_r;
    remain_nxt   = remain_r;
    pulse_nxt    = pulse_r;
    reset_nxt    = o_cpu_reset;
    irq_nxt      = o_irq;
    rdata_nxt    = o_data;
    oe_n_nxt     = o_data_oe_n;
    if (restart) begin
      // New or refreshed interval, any state, restarts in full
      interval_nxt = data_s[IWD_CODE_MSB:0];
      remain_nxt   = data_s[IWD_CODE_MSB:0];
      state_nxt    = IWD_RUN;
      reset_nxt    = 1'b0;
      irq_nxt      = 1'b0;
    end else if (rd_evt) begin
      // Report state as it was, then stop until the next write
      rdata_nxt                 = '0;
      rdata_nxt[IWD_RUN_BIT]    = (state_r == IWD_RUN);
      rdata_nxt[IWD_CODE_MSB:0] = interval_r;
      oe_n_nxt                  = 1'b0;
      state_nxt                 = IWD_IDLE;
      reset_nxt                 = 1'b0;
      irq_nxt                   = 1'b0;
    end else begin
      unique case (state_r)
        IWD_IDLE: begin
          // Nothing counts; a bad code written here leaves us idle
        end
        IWD_RUN: begin
          if (tick) begin
            if (remain_r == 6'h01) begin
              // Interval ran out without a refresh
              state_nxt = IWD_FIRE;
              pulse_nxt = PULSE_LAST;
              reset_nxt = !EXPIRE_IRQ;
              irq_nxt   = EXPIRE_IRQ;
            end else begin
              remain_nxt = remain_r - 6'h01;
            end
          end
        end
        IWD_FIRE: begin
          // Fixed pulse, then stop; software must write again to rearm
          if (pulse_r == '0) begin
            state_nxt = IWD_IDLE;
            reset_nxt = 1'b0;
            irq_nxt   = 1'b0;
          end else begin
            pulse_nxt = pulse_r - IWD_PULSE_W'(1);
          end
        end
      endcase
    end
    if (rd_end) begin
      oe_n_nxt = 1'b1;  // Release the bus when the read strobe ends
    end
    run_nxt = (state_nxt == IWD_RUN);
  end

  // Register the control state; reset leaves the watchdog disabled
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r     <= IWD_IDLE;
      interval_r  <= IWD_INTERVAL_RST;
      remain_r    <= IWD_INTERVAL_RST;
      pulse_r     <= '0;
      o_cpu_reset <= 1'b0;
      o_irq       <= 1'b0;
      o_running   <= 1'b0;
      o_data      <= '0;
      o_data_oe_n <= 1'b1;
    end else begin
      state_r     <= state_nxt;
      interval_r  <= interval_nxt;
      remain_r    <= remain_nxt;
      pulse_r     <= pulse_nxt;
      o_cpu_reset <= reset_nxt;
      o_irq       <= irq_nxt;
      o_running   <= run_nxt;
      o_data      <= rdata_nxt;
      o_data_oe_n <= oe_n_nxt;
    end
  end

endmodule : iwd_top

`default_nettype wire

// ### pkg/iwd_pkg.sv
//----------------------------------------------------------------------
// Notes on behaviour
// - Expiry resets processor or raises interrupt, build option
// - Write to port 443h loads interval, starts counting
// - Codes 01h..3Fh give 1..63 second timeouts
// - Every write of a code 01h..3Fh restarts timing from new interval
// - Read of port 443h stops the watchdog
//----------------------------------------------------------------------
package iwd_pkg;

  //----------------------------------------------------------------------
  // Host I/O port
  //----------------------------------------------------------------------
  localparam int          IWD_ADDR_W       = 16;       // I/O address width
  localparam int          IWD_DATA_W       = 8;        // I/O data width
  localparam logic [15:0] IWD_PORT_ADDR    = 16'h0443; // Interval control port
  localparam logic [7:0]  IWD_CODE_MIN     = 8'h01;    // Shortest interval code
  localparam logic [7:0]  IWD_CODE_MAX     = 8'h3F;    // Longest interval code
  localparam logic [5:0]  IWD_INTERVAL_RST = 6'h00;    // Interval after reset
  localparam int          IWD_RUN_BIT      = 7;        // Read data: running flag
  localparam int          IWD_CODE_MSB     = 5;        // Read data: interval field top

  //----------------------------------------------------------------------
  // Timing
  //----------------------------------------------------------------------
  localparam int IWD_CLK_PERIOD_NS = 40;                            // 25 MHz clock
  localparam int IWD_CLK_KHZ       = 25000;                         // Clock rate in kHz
  localparam int IWD_TICK_MS       = 1000;                          // One second tick
  localparam int IWD_TICK_CYCLES   = IWD_CLK_KHZ * IWD_TICK_MS;     // Cycles per tick
  localparam int IWD_PULSE_NS      = 1000;                          // Least expiry pulse
  localparam int IWD_PULSE_CYCLES  =
    (IWD_PULSE_NS + IWD_CLK_PERIOD_NS - 1) / IWD_CLK_PERIOD_NS;     // Rounded up
  localparam int IWD_PULSE_W       = 16;                            // Pulse counter width

  //----------------------------------------------------------------------
  // Watchdog states
  //----------------------------------------------------------------------
  typedef enum logic [1:0] {
    IWD_IDLE,   // Stopped, no expiry possible
    IWD_RUN,    // Counting seconds down
    IWD_FIRE    // Expiry pulse being driven
  } iwd_state_t;

endpackage : iwd_pkg

// ### tb/iwd_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module iwd_chk
  import iwd_pkg::*;
#(
  parameter int TICK_CYCLES  = IWD_TICK_CYCLES,
  parameter int PULSE_CYCLES = IWD_PULSE_CYCLES,
  parameter bit EXPIRE_IRQ   = 1'b0
) (
  input wire logic                  i_clock,
  input wire logic                  i_resetn,
  input wire logic [IWD_ADDR_W-1:0] i_io_addr,
  input wire logic                  i_aen,
  input wire logic                  i_iow_n,
  input wire logic                  i_ior_n,
  input wire logic [IWD_DATA_W-1:0] i_data,
  input wire logic [IWD_DATA_W-1:0] o_data,
  input wire logic                  o_data_oe_n,
  input wire logic                  o_cpu_reset,
  input wire logic                  o_irq,
  input wire logic                  o_running
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  logic sel;  // Our port, not a DMA cycle
  logic good; // Interval code in range
  logic fire; // Expiry line of the chosen kind
  int   hi_r; // Cycles the expiry line has been high
  assign sel  = (i_io_addr == IWD_PORT_ADDR) && !i_aen;
  assign good = (i_data >= IWD_CODE_MIN) && (i_data <= IWD_CODE_MAX);
  assign fire = EXPIRE_IRQ ? o_irq : o_cpu_reset;
  // Pulse length count, so long pulses need no long repetition
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      hi_r <= 0;
    end else begin
      hi_r <= fire ? hi_r + 1 : 0;
    end
  end
  wr_start_a: assert property ($fell(i_iow_n) && sel && good |-> ##[2:7] o_running)
    else $error("valid write did not start counting");
  rd_stop_a: assert property ($fell(i_ior_n) && sel |-> ##[2:7] (!o_running && !o_data_oe_n))
    else $error("read did not stop counting");
  bad_code_a: assert property ($fell(i_iow_n) && !good && !o_running |-> ##1 !o_running[*8])
    else $error("bad code started counting");
  fire_cause_a: assert property ($rose(fire) |-> $past(o_running))
    else $error("expiry while not counting");
  other_quiet_a: assert property (EXPIRE_IRQ ? !o_cpu_reset : !o_irq)
    else $error("wrong expiry kind");
  pulse_len_a: assert property ($fell(fire) |-> hi_r >= PULSE_CYCLES)
    else $error("expiry pulse too short");
  rst_idle_a: assert property ($rose(i_resetn) |-> !o_running && o_data_oe_n && !fire)
    else $error("not idle after reset");
  restart_a: assert property ($fell(i_iow_n) && sel && good |-> ##5 !fire[*8])
    else $error("expiry right after a write");
  cover property ($rose(fire));
  cover property ($fell(o_data_oe_n) && o_data[IWD_RUN_BIT]);
  cover property ($fell(i_iow_n) && sel && good && o_running);
endmodule : iwd_chk
`default_nettype wire

// ### tb/iwd_host.sv
`timescale 1ns/1ps
`default_nettype none
module iwd_host
  import iwd_pkg::*;
(
  input  wire logic                  i_clock,
  output var  logic [IWD_ADDR_W-1:0] o_io_addr,
  output var  logic                  o_aen,
  output var  logic                  o_iow_n,
  output var  logic                  o_ior_n,
  output var  logic [IWD_DATA_W-1:0] o_data
);
  initial begin
    o_io_addr = 16'h0000;
    o_aen     = 1'b0;
    o_iow_n   = 1'b1;
    o_ior_n   = 1'b1;
    o_data    = 8'h00;
  end
  // One I/O cycle; released lines flip so stale values never pass
  task automatic cyc(input logic [15:0] a, input logic e, input logic w, input logic [7:0] d);
    @(posedge i_clock);
    o_io_addr <= a;
    o_aen     <= e;
    o_data    <= d;
    repeat (4) @(posedge i_clock);
    if (w) begin
      o_iow_n <= 1'b0;
    end else begin
      o_ior_n <= 1'b0;
    end
    repeat (6) @(posedge i_clock);
    o_iow_n <= 1'b1;
    o_ior_n <= 1'b1;
    repeat (5) @(posedge i_clock);
    o_io_addr <= ~a;
    o_data    <= ~d;
  endtask : cyc
endmodule : iwd_host
`default_nettype wire

// ### tb/test_io_port_watchdog_timer.sv
`timescale 1ns/1ps
`default_nettype none
module test_io_port_watchdog_timer;
  import iwd_pkg::*;
  localparam int T = 20; // Short second for simulation
  localparam int P = 4;  // Short expiry pulse
  logic        i_clock  = 1'b0;
  logic        i_resetn = 1'b0;
  logic [15:0] io_addr;
  logic        aen, iow_n, ior_n, oe_n, cpu_rst, irq, running;
  logic        irq_b, rst_b; // Expiry lines of the interrupt-mode twin
  logic [7:0]  host_d, bus_d, rd_d;
  logic [7:0]  exp_q[$];
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          cyc_cnt   = 0;
  int          n, seed;
  always #20 i_clock = ~i_clock;
  // Shared data bus: device wins while it drives
  assign bus_d = oe_n ? host_d : rd_d;
  iwd_host host_u (.i_clock(i_clock), .o_io_addr(io_addr), .o_aen(aen), .o_iow_n(iow_n),
    .o_ior_n(ior_n), .o_data(host_d));
  iwd_top #(.TICK_CYCLES(T), .PULSE_CYCLES(P), .EXPIRE_IRQ(1'b0)) dut_u (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_io_addr(io_addr), .i_aen(aen),
    .i_iow_n(iow_n), .i_ior_n(ior_n), .i_data(bus_d), .o_data(rd_d), .o_data_oe_n(oe_n),
    .o_cpu_reset(cpu_rst), .o_irq(irq), .o_running(running));
  // Twin built for interrupt expiry, same bus, so both must fire together
  iwd_top #(.TICK_CYCLES(T), .PULSE_CYCLES(P), .EXPIRE_IRQ(1'b1)) dut_irq_u (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_io_addr(io_addr), .i_aen(aen),
    .i_iow_n(iow_n), .i_ior_n(ior_n), .i_data(bus_d), .o_data(), .o_data_oe_n(),
    .o_cpu_reset(rst_b), .o_irq(irq_b), .o_running());
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  // Hang guard, far above the expected run of about 2000 cycles
  always @(posedge i_clock) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  // Read watcher: oldest note against what the port drove
  always @(negedge oe_n) begin
    #1;
    if (exp_q.size() == 0) begin
      check("unexpected read", 8'h01, 8'h00);
    end else begin
      check("read data", rd_d, exp_q.pop_front());
    end
  end
  task automatic wr(input logic [7:0] d, input logic [15:0] a = IWD_PORT_ADDR, input logic e = 0);
    host_u.cyc(a, e, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] want);
    exp_q.push_back(want);
    host_u.cyc(IWD_PORT_ADDR, 1'b0, 1'b0, 8'h00);
  endtask : rd
  task automatic fire_wait(input int lim, output int cnt);
    cnt = 0;
    while (cpu_rst !== 1'b1 && cnt < lim) begin
      @(negedge i_clock); // Sample away from the launching edge
      cnt++;
    end
  endtask : fire_wait
  // Write a code and time the expiry from the end of the write
  task automatic expire(input logic [7:0] code);
    int k;
    wr(code);
    @(negedge i_clock);
    check("running", {7'h00, running}, 8'h01);
    fire_wait(int'(code) * T + 20, k);
    check("expiry", {7'h00, k >= int'(code) * T - 12 && k <= int'(code) * T}, 8'h01);
    check("expiry kind", {5'h00, rst_b, irq_b, irq}, 8'h02);
    repeat (P + 4) @(posedge i_clock);
  endtask : expire
  initial begin
    seed = $urandom(32'h62AF);
    repeat (12) @(posedge i_clock);
    i_resetn <= 1'b1;
    check("running", {7'h00, running}, 8'h00);
    rd(8'h00);
    // Refused: bad codes, other address, DMA cycle
    wr(8'h00);
    wr(8'h40);
    wr(8'h01, 16'h0442);
    wr(8'h01, IWD_PORT_ADDR, 1'b1);
    @(negedge i_clock);
    check("running", {7'h00, running}, 8'h00);
    expire(8'h01);
    expire(8'h3F);
    expire(8'h01 + 8'($urandom % 8));
    // Refresh after the first second, before the old expiry, restarts in full
    wr(8'h02);
    repeat (T) @(posedge i_clock);
    expire(8'h02);
    // Read stops the count and reports it was running
    wr(8'h03);
    rd(8'h83);
    fire_wait(4 * T, n);
    check("stopped", {7'h00, cpu_rst}, 8'h00);
    rd(8'h03);
    // Reset in mid-count leaves it idle
    wr(8'h05);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_resetn <= 1'b1;
    fire_wait(6 * T, n);
    check("idle", {5'h00, irq_b, cpu_rst, running}, 8'h00);
    rd(8'h00);
    summarize();
  end
endmodule : test_io_port_watchdog_timer
bind iwd_top iwd_chk #(.TICK_CYCLES(TICK_CYCLES), .PULSE_CYCLES(PULSE_CYCLES),
  .EXPIRE_IRQ(EXPIRE_IRQ)) chk_u (.i_clock(i_clock), .i_resetn(i_resetn),
  .i_io_addr(i_io_addr), .i_aen(i_aen), .i_iow_n(i_iow_n), .i_ior_n(i_ior_n),
  .i_data(i_data), .o_data(o_data), .o_data_oe_n(o_data_oe_n), .o_cpu_reset(o_cpu_reset),
  .o_irq(o_irq), .o_running(o_running));
`default_nettype wire
